// [tb/gl_plant_model.sv]
// Output stage readback and external relay feedback seen by the controller.
module gl_plant_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic safety_output_a,
   input wire logic safety_output_b,
   input wire logic short_fault,
   input wire logic weld_fault,
   output logic [1:0] out_readback,
   output logic feedback_monitor
);
   timeunit 1ns;
   timeprecision 1ps;
   logic relay_q;
   // Readback lags the outputs by one cycle; a short pulls both lines high.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_readback <= 2'h0;
      end else if (short_fault) begin
         out_readback <= 2'h3;
      end else begin
         out_readback <= {safety_output_a, safety_output_b};
      end
   end
   // The relay follows both outputs; a welded contact keeps feedback low.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         relay_q <= 1'b0;
      end else begin
         relay_q <= safety_output_a & safety_output_b;
      end
   end
   assign feedback_monitor = weld_fault ? 1'b0 : ~relay_q;
endmodule : gl_plant_model

// [tb/tb.sv]
// Self-checking testbench of the guard-lock controller.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gl_pkg::*;
   typedef struct packed {
      logic mode;
      logic [1:0] ins;
      logic [2:0] zone;
      logic lck;
      logic [2:0] ex;
   } gl_row_t;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic safety_input_a = 1'b1;
   logic safety_input_b = 1'b1;
   gl_sense_t sense = gl_sense_t'(3'h7);
   logic lock_command_input = 1'b1;
   logic feedback_monitor;
   logic [1:0] out_readback;
   logic supply_ok = 1'b1;
   logic test_pass = 1'b1;
   logic short_fault = 1'b0;
   logic weld_fault = 1'b0;
   logic safety_output_a, safety_output_b;
   logic door_closed_signal, guard_locked_signal, test_req;
   logic lock_drive;
   gl_ind_t ind;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;
   int n;
   logic cur_mode = 1'b0;
   logic [DATA_W-1:0] rdat;
   gl_row_t rows [12];

   gl_guard_lock_ctrl #(.POST_CYC(8), .PERIOD_CYC(20), .SETTLE_CYC(3),
      .EDM_CYC(5)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
      .sense(sense), .lock_command_input(lock_command_input),
      .feedback_monitor(feedback_monitor), .out_readback(out_readback),
      .supply_ok(supply_ok), .test_pass(test_pass),
      .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
      .door_closed_signal(door_closed_signal),
      .guard_locked_signal(guard_locked_signal), .lock_drive(lock_drive),
      .test_req(test_req), .ind(ind));

   gl_plant_model i_plant (.core_clk(core_clk), .reset_n(reset_n),
      .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
      .short_fault(short_fault), .weld_fault(weld_fault),
      .out_readback(out_readback), .feedback_monitor(feedback_monitor));

   always #20 core_clk = ~core_clk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rdat = reg_rdata;
   endtask : rd

   task automatic wait_run();
      int k;
      k = 0;
      rdat = '0;
      while (rdat[9:8] !== 2'h1 && k < 40) begin
         rd(ADDR_STATUS);
         k++;
      end
      check("run state", {14'h0, rdat[9:8]}, 16'h0001);
   endtask : wait_run

   task automatic restart(input logic [DATA_W-1:0] ctrl);
      wr(ADDR_CTRL, ctrl | 16'h0004);
      wait_run();
      cur_mode = ctrl[0];
   endtask : restart

   task automatic apply(input gl_row_t r);
      @(posedge core_clk);
      safety_input_a <= r.ins[1];
      safety_input_b <= r.ins[0];
      sense <= gl_sense_t'(r.zone);
      lock_command_input <= r.lck;
      repeat (4) @(posedge core_clk);
      #1;
   endtask : apply

   task automatic outs(input logic [2:0] e);
      check("outputs", {8'h0, safety_output_a, safety_output_b,
         door_closed_signal, guard_locked_signal, ind.outputs, ind.presence,
         ind.lock, ind.supply}, {8'h0, e[2], e[2], e[1], e[0], e[2], e[1],
         e[0], 1'b1});
   endtask : outs

   task automatic fault_bit(input int b);
      rd(ADDR_FAULT);
      check("fault flag", {15'h0, rdat[b]}, 16'h0001);
      rd(ADDR_STATUS);
      check("error state", {14'h0, rdat[9:8]}, 16'h0002);
      check("safety outputs", {14'h0, safety_output_a, safety_output_b},
         16'h0000);
   endtask : fault_bit

   initial begin
      rows = '{'{1'h0, 2'h3, 3'h0, 1'h0, 3'h0}, '{1'h0, 2'h3, 3'h6, 1'h0, 3'h2},
         '{1'h0, 2'h3, 3'h7, 1'h1, 3'h7}, '{1'h0, 2'h3, 3'h3, 1'h1, 3'h7},
         '{1'h0, 2'h3, 3'h2, 1'h0, 3'h0}, '{1'h0, 2'h2, 3'h7, 1'h1, 3'h3},
         '{1'h0, 2'h3, 3'h7, 1'h1, 3'h7}, '{1'h0, 2'h3, 3'h6, 1'h0, 3'h2},
         '{1'h0, 2'h3, 3'h0, 1'h0, 3'h0}, '{1'h1, 2'h3, 3'h6, 1'h0, 3'h6},
         '{1'h1, 2'h3, 3'h0, 1'h0, 3'h0}, '{1'h1, 2'h1, 3'h6, 1'h0, 3'h2}};
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (5) begin
         @(posedge core_clk);
         #1;
         check("power-up outputs", {11'h0, safety_output_a, safety_output_b,
            door_closed_signal, guard_locked_signal, ind.outputs},
            16'h0000);
         check("power-up test", {15'h0, test_req}, 16'h0001);
      end
      wait_run();
      rd(4'hC);
      check("unmapped read", rdat, 16'h0000);
      rd(ADDR_CTRL);
      check("ctrl reset", rdat, CTRL_RESET);
      $display("power-up test done");
      foreach (rows[i]) begin
         if (rows[i].mode !== cur_mode) begin
            restart({15'h0, rows[i].mode});
         end
         apply(rows[i]);
         outs(rows[i].ex);
         check("lock drive", {15'h0, lock_drive},
            {15'h0, rows[i].ex[1] && rows[i].lck});
         check("input indicator", {15'h0, ind.inputs},
            {15'h0, rows[i].ins == 2'h3});
         rd(ADDR_STATUS);
         check("incoherence", {15'h0, rdat[10]},
            {15'h0, rows[i].ins != 2'h3});
         check("active mode", {15'h0, rdat[11]}, {15'h0, rows[i].mode});
         $display("row %0d done", i);
      end
      rd(ADDR_CTRL);
      check("ctrl readback", rdat, 16'h0001);
      apply(rows[10]);
      short_fault <= 1'b1;
      repeat (10) @(posedge core_clk);
      short_fault <= 1'b0;
      apply(rows[9]);
      fault_bit(FLT_OUT_BIT);
      restart(16'h0001);
      apply(rows[9]);
      outs(3'h6);
      $display("output fault test done");
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         #1;
         if (test_req === 1'b1) begin
            n++;
         end
      end
      check("self-test pulses", n[15:0], 16'h0002);
      supply_ok <= 1'b0;
      repeat (4) @(posedge core_clk);
      supply_ok <= 1'b1;
      fault_bit(FLT_INT_BIT);
      $display("supply test done");
      restart(16'h0003);
      rd(ADDR_STATUS);
      check("feedback active", {15'h0, rdat[12]}, 16'h0001);
      apply(rows[10]);
      outs(3'h0);
      check("feedback shown", {15'h0, ind.feedback}, 16'h0001);
      weld_fault <= 1'b1;
      apply(rows[9]);
      check("feedback hold", {14'h0, safety_output_a, safety_output_b},
         16'h0000);
      weld_fault <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      check("feedback release", {14'h0, safety_output_a, safety_output_b},
         16'h0003);
      weld_fault <= 1'b1;
      apply(rows[10]);
      repeat (8) @(posedge core_clk);
      weld_fault <= 1'b0;
      fault_bit(FLT_EDM_BIT);
      $display("feedback test done");
      @(posedge core_clk);
      test_pass <= 1'b0;
      wr(ADDR_CTRL, 16'h0004);
      repeat (14) @(posedge core_clk);
      test_pass <= 1'b1;
      fault_bit(FLT_INT_BIT);
      $display("self-test failure test done");
      restart(16'h0000);
      @(posedge core_clk);
      sense <= gl_sense_t'(3'h4);
      repeat (3) @(posedge core_clk);
      fault_bit(FLT_DET_BIT);
      $display("zone detect test done");
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1;
      check("reset outputs", {11'h0, safety_output_a, safety_output_b,
         door_closed_signal, guard_locked_signal, ind.outputs},
         16'h0000);
      check("reset test", {15'h0, test_req}, 16'h0001);
      $display("mid-run reset test done");
      test_done();
   end
endmodule : tb

// [verilog/gl_guard_lock_ctrl.sv]
// Decision logic of a coded guard-locking safety switch.
module gl_guard_lock_ctrl import gl_pkg::*; #(
   parameter int POST_CYC = POST_CYCLES,
   parameter int PERIOD_CYC = TEST_PERIOD_CYCLES,
   parameter int SETTLE_CYC = SETTLE_CYCLES,
   parameter int EDM_CYC = EDM_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic safety_input_a,
   input wire logic safety_input_b,
   input wire gl_sense_t sense,
   input wire logic lock_command_input,
   input wire logic feedback_monitor,
   input wire logic [1:0] out_readback,
   input wire logic supply_ok,
   input wire logic test_pass,
   output logic safety_output_a,
   output logic safety_output_b,
   output logic door_closed_signal,
   output logic guard_locked_signal,
   output logic lock_drive,
   output logic test_req,
   output gl_ind_t ind
);
   localparam int EW = $clog2(EDM_CYC + 1) + 1;

   gl_state_t state_q, state_d;
   logic [DATA_W-1:0] ctrl_q;
   logic mode2_q, edm_on_q;
   logic restart;
   logic post_done, int_fault, out_fault;
   logic det_fault_q, edm_fault_q;
   logic [EW-1:0] edm_cnt_q;
   logic locked_q, incoh_q;
   logic err_now, run_d, present_d, locked_d, inputs_ok, edm_ready, en_d;
   logic mode2_d, edm_on_d;

   generate
      if (EDM_CYC < 1) begin : g_bad_edm
         $error("gl_guard_lock_ctrl: feedback time must be at least 1");
      end
   endgenerate

   gl_supervisor #(
      .POST_CYC(POST_CYC),
      .PERIOD_CYC(PERIOD_CYC)
   ) u_super (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(restart),
      .supply_ok(supply_ok),
      .test_pass(test_pass),
      .test_req_q(test_req),
      .post_done_q(post_done),
      .int_fault_q(int_fault)
   );

   gl_out_check #(
      .SETTLE_CYC(SETTLE_CYC)
   ) u_out_chk (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(restart),
      .cmd({safety_output_a, safety_output_b}),
      .readback(out_readback),
      .fault_q(out_fault)
   );

   // Register port: control word, restart side effect and read data.
   assign restart = reg_wr && gl_hit(reg_addr, ADDR_CTRL) &&
                    reg_wdata[CTRL_RESTART_BIT];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (reg_wr && gl_hit(reg_addr, ADDR_CTRL)) begin
         ctrl_q <= reg_wdata & ~(DATA_W'(1) << CTRL_RESTART_BIT);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (!reg_rd) begin
         reg_rdata <= '0;
      end else if (gl_hit(reg_addr, ADDR_CTRL)) begin
         reg_rdata <= ctrl_q;
      end else if (gl_hit(reg_addr, ADDR_STATUS)) begin
         reg_rdata <= '0;
         reg_rdata[STAT_IND_LSB +: $bits(gl_ind_t)] <= ind;
         reg_rdata[STAT_STATE_LSB +: $bits(gl_state_t)] <= state_q;
         reg_rdata[STAT_INCOH_BIT] <= incoh_q;
         reg_rdata[STAT_MODE_BIT] <= mode2_q;
         reg_rdata[STAT_EDM_BIT] <= edm_on_q;
      end else if (gl_hit(reg_addr, ADDR_FAULT)) begin
         reg_rdata <= '0;
         reg_rdata[FLT_INT_BIT] <= int_fault;
         reg_rdata[FLT_OUT_BIT] <= out_fault;
         reg_rdata[FLT_DET_BIT] <= det_fault_q;
         reg_rdata[FLT_EDM_BIT] <= edm_fault_q;
      end else begin
         reg_rdata <= '0;
      end
   end

   // Next-cycle decisions; safety outputs, lock_drive and all of ind but supply and feedback load from these together.
   always_comb begin
      err_now = int_fault || out_fault || det_fault_q || edm_fault_q;
      state_d = state_q;
      case (state_q)
         GL_POST: begin
            if (err_now) begin
               state_d = GL_ERROR;
            end else if (post_done) begin
               state_d = GL_RUN;
            end
         end
         GL_RUN: begin
            if (err_now) begin
               state_d = GL_ERROR;
            end
         end
         GL_ERROR: begin
            state_d = GL_ERROR;
         end
         default: begin
            state_d = GL_ERROR;
         end
      endcase
      if (restart) begin
         state_d = GL_POST;
      end
      // The mode taken on entering run already governs that first cycle.
      if (state_q == GL_POST && state_d == GL_RUN) begin
         mode2_d = ctrl_q[CTRL_MODE_BIT];
         edm_on_d = ctrl_q[CTRL_EDM_BIT];
      end else begin
         mode2_d = mode2_q;
         edm_on_d = edm_on_q;
      end
      run_d = state_d == GL_RUN;
      inputs_ok = safety_input_a && safety_input_b;
      // Locked actuator tolerates the wider zone, released the narrow one.
      present_d = run_d && (locked_q ? sense.zone_wide
                                     : sense.zone_narrow);
      locked_d = present_d && lock_command_input && lock_drive &&
                 sense.lock_sensed;
      edm_ready = !edm_on_d || feedback_monitor || safety_output_a;
      en_d = present_d && inputs_ok && edm_ready &&
             (mode2_d || locked_d);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= GL_POST;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode2_q <= 1'b0;
         edm_on_q <= 1'b0;
      end else begin
         mode2_q <= mode2_d;
         edm_on_q <= edm_on_d;
      end
   end

   // Lock solenoid follows the command only with the actuator present.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_drive <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         lock_drive <= present_d && lock_command_input;
         locked_q <= locked_d;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         safety_output_a <= 1'b0;
         safety_output_b <= 1'b0;
         door_closed_signal <= 1'b0;
         guard_locked_signal <= 1'b0;
      end else begin
         safety_output_a <= en_d;
         safety_output_b <= en_d;
         door_closed_signal <= present_d;
         guard_locked_signal <= locked_d;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ind <= '0;
         incoh_q <= 1'b0;
      end else begin
         ind.supply <= supply_ok && !int_fault;
         ind.inputs <= run_d && inputs_ok;
         ind.outputs <= en_d;
         ind.presence <= present_d;
         ind.lock <= locked_d;
         ind.feedback <= edm_on_q && feedback_monitor;
         incoh_q <= safety_input_a != safety_input_b;
      end
   end

   // A zone hit in the narrow limits but not the wide ones is impossible.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         det_fault_q <= 1'b0;
      end else if (state_q != GL_POST && sense.zone_narrow &&
                   !sense.zone_wide) begin
         det_fault_q <= 1'b1;
      end else if (restart) begin
         det_fault_q <= 1'b0;
      end
   end

   // Feedback must go low while outputs are on, high while they are off.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         edm_cnt_q <= '0;
      end else if (restart || !edm_on_q ||
                   safety_output_a != feedback_monitor) begin
         edm_cnt_q <= '0;
      end else if (edm_cnt_q != EW'(EDM_CYC)) begin
         edm_cnt_q <= edm_cnt_q + 1'b1;
      end
   end

   // A trip in the cycle of a restart survives it.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         edm_fault_q <= 1'b0;
      end else if (edm_on_q && safety_output_a == feedback_monitor &&
                   edm_cnt_q == EW'(EDM_CYC)) begin
         edm_fault_q <= 1'b1;
      end else if (restart || !edm_on_q) begin
         edm_fault_q <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   a_mode1_lock: assert property (safety_output_a && !mode2_q
      |-> guard_locked_signal && ind.lock && door_closed_signal)
      else $error("safety outputs on in mode 1 without lock");
   a_inputs_needed: assert property ($rose(safety_output_a)
      |-> $past(safety_input_a) && $past(safety_input_b))
      else $error("safety outputs rose without both inputs");
   a_incoh_off: assert property (safety_input_a != safety_input_b
      |=> !safety_output_a && incoh_q)
      else $error("incoherent inputs did not hold outputs off");
   a_pair_same: assert property (safety_output_a == safety_output_b)
      else $error("safety output pair differs");
   a_unlock_drop: assert property ($fell(guard_locked_signal) && !mode2_q
      |-> !safety_output_a && !ind.lock)
      else $error("unlock did not drop outputs together");
   a_mode2_absent: assert property (mode2_q && !door_closed_signal
      |-> !safety_output_a)
      else $error("mode 2 outputs on without presence");
   a_error_hold: assert property (state_q == GL_ERROR && !restart
      |=> state_q == GL_ERROR && !safety_output_a)
      else $error("error state left without restart");
   a_post_quiet: assert property (state_q == GL_POST
      |-> !safety_output_a && !door_closed_signal && !guard_locked_signal)
      else $error("outputs active before self-test done");
   a_supply_trip: assert property (!supply_ok
      |-> ##2 state_q != GL_RUN)
      else $error("supply loss did not stop the device");
   a_lock_zone: assert property (locked_q && sense.zone_wide &&
      state_d == GL_RUN |=> door_closed_signal)
      else $error("locked actuator lost presence in wide zone");

   // Fault trips, zone limits, lock path, mode latching and indicator match.
   a_det_trip: assert property (state_q != GL_POST &&
      sense.zone_narrow && !sense.zone_wide |=> det_fault_q)
      else $error("zone detect fault not raised");
   a_edm_trip: assert property (edm_on_q &&
      safety_output_a == feedback_monitor &&
      edm_cnt_q == EW'(EDM_CYC) |=> edm_fault_q)
      else $error("feedback fault not raised");
   a_lock_release: assert property (!lock_command_input
      |=> !guard_locked_signal && !lock_drive && !ind.lock)
      else $error("unlock command left the lock asserted");
   a_narrow_zone: assert property (!locked_q && !sense.zone_narrow
      |=> !door_closed_signal && !ind.presence)
      else $error("released actuator kept presence outside zone");
   a_door_zone: assert property (state_d == GL_RUN && !locked_q &&
      sense.zone_narrow |=> door_closed_signal && ind.presence)
      else $error("actuator in zone not shown as present");
   a_fault_error: assert property (out_fault && !restart
      |=> state_q == GL_ERROR)
      else $error("output fault did not stop the device");
   a_mode_static: assert property (state_q != GL_POST
      |=> $stable(mode2_q) && $stable(edm_on_q))
      else $error("mode changed outside self-test");
   a_lock_drive: assert property ($rose(guard_locked_signal)
      |-> $past(lock_drive) && door_closed_signal)
      else $error("lock reported without solenoid drive");
   a_ind_match: assert property (ind.outputs == safety_output_a &&
      ind.presence == door_closed_signal && ind.lock == guard_locked_signal)
      else $error("indicators differ from the outputs");

   c_mode1_on: cover property (!mode2_q && $rose(safety_output_a));
   c_mode2_on: cover property (mode2_q && $rose(safety_output_a));
   c_error_in: cover property ($rose(state_q == GL_ERROR));
   c_unlock: cover property ($fell(guard_locked_signal));
   c_edm_trip: cover property ($rose(edm_fault_q));
endmodule : gl_guard_lock_ctrl

// [verilog/gl_out_check.sv]
// Readback check of the two safety outputs against their commands.
module gl_out_check import gl_pkg::*; #(
   parameter int SETTLE_CYC = SETTLE_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic restart,
   input wire logic [1:0] cmd,
   input wire logic [1:0] readback,
   output logic fault_q
);
   localparam int CW = $clog2(SETTLE_CYC + 1) + 1;

   logic [1:0] cmd_q;
   logic [CW-1:0] cnt_q;

   generate
      if (SETTLE_CYC < 1) begin : g_bad
         $error("gl_out_check: settle count must be at least 1");
      end
   endgenerate

   // The settle timer restarts whenever the commanded pair changes.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= 2'h0;
         cnt_q <= '0;
      end else begin
         cmd_q <= cmd;
         if (cmd != cmd_q) begin
            cnt_q <= '0;
         end else if (cnt_q != CW'(SETTLE_CYC)) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_q <= 1'b0;
      end else if (cnt_q == CW'(SETTLE_CYC) && readback != cmd_q) begin
         fault_q <= 1'b1;
      end else if (restart) begin
         fault_q <= 1'b0;
      end
   end
endmodule : gl_out_check

// [verilog/gl_pkg.sv]
// Shared constants, types and decode helpers of the guard-lock controller.
package gl_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int POST_TIME_US = 1000;
   localparam int POST_CYCLES = POST_TIME_US * CYC_PER_US;
   localparam int TEST_PERIOD_US = 10000;
   localparam int TEST_PERIOD_CYCLES = TEST_PERIOD_US * CYC_PER_US;
   localparam int SETTLE_TIME_NS = 2000;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * CYC_PER_US + 999) / 1000;
   localparam int EDM_TIME_US = 100;
   localparam int EDM_CYCLES = EDM_TIME_US * CYC_PER_US;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_FAULT = 4'h8;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_EDM_BIT = 1;
   localparam int CTRL_RESTART_BIT = 2;
   localparam int STAT_IND_LSB = 0;
   localparam int STAT_STATE_LSB = 8;
   localparam int STAT_INCOH_BIT = 10;
   localparam int STAT_MODE_BIT = 11;
   localparam int STAT_EDM_BIT = 12;
   localparam int FLT_INT_BIT = 0;
   localparam int FLT_OUT_BIT = 1;
   localparam int FLT_DET_BIT = 2;
   localparam int FLT_EDM_BIT = 3;

   typedef enum logic [1:0] {GL_POST, GL_RUN, GL_ERROR} gl_state_t;

   typedef struct packed {
      logic zone_narrow;
      logic zone_wide;
      logic lock_sensed;
   } gl_sense_t;

   typedef struct packed {
      logic supply;
      logic inputs;
      logic outputs;
      logic presence;
      logic lock;
      logic feedback;
   } gl_ind_t;

   function automatic logic gl_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] target);
      return addr == target;
   endfunction : gl_hit
endpackage : gl_pkg

// [verilog/gl_supervisor.sv]
// Power-on self-test, recurring self-test and supply supervision.
module gl_supervisor import gl_pkg::*; #(
   parameter int POST_CYC = POST_CYCLES,
   parameter int PERIOD_CYC = TEST_PERIOD_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic restart,
   input wire logic supply_ok,
   input wire logic test_pass,
   output logic test_req_q,
   output logic post_done_q,
   output logic int_fault_q
);
   localparam int MAXC = (PERIOD_CYC > POST_CYC) ? PERIOD_CYC : POST_CYC;
   localparam int CW = $clog2(MAXC) + 1;

   logic [CW-1:0] cnt_q;
   logic check_q;

   generate
      if (POST_CYC < 2 || PERIOD_CYC < 2) begin : g_bad
         $error("gl_supervisor: test counts must be at least 2");
      end
   endgenerate

   // The test request is held through power-on, then pulsed once a period.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         test_req_q <= 1'b0;
         post_done_q <= 1'b0;
         check_q <= 1'b0;
      end else if (restart) begin
         cnt_q <= '0;
         test_req_q <= 1'b0;
         post_done_q <= 1'b0;
         check_q <= 1'b0;
      end else if (!post_done_q) begin
         test_req_q <= 1'b1;
         check_q <= 1'b0;
         if (cnt_q == CW'(POST_CYC - 1)) begin
            cnt_q <= '0;
            post_done_q <= 1'b1;
            test_req_q <= 1'b0;
            check_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end else begin
         check_q <= test_req_q;
         if (cnt_q == CW'(PERIOD_CYC - 1)) begin
            cnt_q <= '0;
            test_req_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
            test_req_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_fault_q <= 1'b0;
      end else if (!supply_ok || (check_q && !test_pass)) begin
         int_fault_q <= 1'b1;
      end else if (restart) begin
         int_fault_q <= 1'b0;
      end
   end
endmodule : gl_supervisor
